/* common/tlos_pkg.sv */
// Shared constants and types for the transmit line output select block.
package tlos_pkg;

   // ==========================================================
   // Output modes, one-hot.
   typedef enum logic [3:0] {
      TLOS_MODE_OFF     = 4'h1,
      TLOS_MODE_ANALOG  = 4'h2,
      TLOS_MODE_DUAL    = 4'h4,
      TLOS_MODE_OPTICAL = 4'h8
   } tlos_mode_t;

   // ==========================================================
   // Layout of one buffered symbol.
   localparam int TLOS_ENT_POS = 0;
   localparam int TLOS_ENT_NEG = 1;
   localparam int TLOS_ENT_BIT = 2;
   localparam int TLOS_ENT_FRM = 3;
   localparam int TLOS_ENT_W = 4;
   localparam int TLOS_BUF_DEPTH = 2;

   // ==========================================================
   // Control bit meanings and reset values.
   localparam logic TLOS_POL_RESET = 1'b0;
   localparam logic TLOS_CODE_NRZ = 1'b0;
   localparam logic TLOS_CODE_CMI = 1'b1;
   localparam logic TLOS_BAUD_HALF = 1'b0;
   localparam logic TLOS_BAUD_FULL = 1'b1;

   // ==========================================================
   // Nominal optical line rate, set by the transmit clock.
   localparam int TLOS_OPT_RATE_KBPS = 2048;

endpackage

/* design/tlos_edge_sync.sv */
// Two-stage synchroniser with rise and fall detection for an outside clock.
`timescale 1ns/10ps
`default_nettype none
module tlos_edge_sync (
   input wire logic ref_clk,  // System clock.
   input wire logic resetn,   // Asynchronous reset, active low.
   input wire logic async_in, // Level from outside the clock domain.
   output logic level_out,    // Synchronised level.
   output logic rise_pulse,   // One cycle on a rising edge.
   output logic fall_pulse    // One cycle on a falling edge.
);

   logic meta_reg;
   logic sync_reg;
   logic hist_reg;

   // ==========================================================
   // Synchroniser chain; only sync_reg reads meta_reg.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         hist_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         hist_reg <= sync_reg;
      end
   end

   assign level_out = sync_reg;
   assign rise_pulse = sync_reg & ~hist_reg;
   assign fall_pulse = ~sync_reg & hist_reg;

endmodule
`default_nettype wire

/* design/tlos_skid_buf.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module tlos_skid_buf #(
   parameter int WIDTH = tlos_pkg::TLOS_ENT_W,
   parameter int DEPTH = tlos_pkg::TLOS_BUF_DEPTH
) (
   input wire logic ref_clk,             // System clock.
   input wire logic resetn,              // Asynchronous reset, active low.
   input wire logic wr_valid,            // Source offers a word.
   output logic wr_ready,                // Buffer has room.
   input wire logic [WIDTH-1:0] wr_data, // Word from the source.
   output logic rd_valid,                // Buffer holds a word.
   input wire logic rd_ready,            // Drain takes the word.
   output logic [WIDTH-1:0] rd_data      // Oldest word.
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wp_reg;
   logic [PW-1:0] rp_reg;
   logic [PW:0] cnt_reg;
   logic do_wr;
   logic do_rd;

   assign wr_ready = (cnt_reg != (PW+1)'(DEPTH));
   assign rd_valid = (cnt_reg != '0);
   assign rd_data = mem_reg[rp_reg];
   assign do_wr = wr_valid & wr_ready;
   assign do_rd = rd_valid & rd_ready;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   // ==========================================================
   // Storage.
   always_ff @(posedge ref_clk) begin
      if (do_wr) begin
         mem_reg[wp_reg] <= wr_data;
      end
   end

   // ==========================================================
   // Pointers and fill count.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (do_wr) begin
            wp_reg <= ptr_inc(wp_reg);
         end
         if (do_rd) begin
            rp_reg <= ptr_inc(rp_reg);
         end
         if (do_wr && !do_rd) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (do_rd && !do_wr) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

/* design/tlos_line_out.sv */
// Transmit line output stage: analog, dual-rail and optical forms.
`timescale 1ns/10ps
`default_nettype none
module tlos_line_out (
   input wire logic ref_clk,              // System clock, 100 MHz.
   input wire logic resetn,               // Asynchronous reset, active low.
   input wire logic transmit_clock,       // Transmit bit clock from outside.
   input wire logic digital_rail_select,  // 1 selects a digital form.
   input wire logic transmit_coding_ctrl, // Coding bit, 1 dual-rail.
   input wire logic tx_baud_width_sel,    // 0 half baud, 1 full baud.
   input wire logic tx_output_polarity,   // Output sense select.
   input wire logic tx_optical_code_sel,  // 0 NRZ, 1 CMI on optical.
   input wire logic in_valid,             // Framer offers a symbol.
   output logic in_ready,                 // Buffer has room.
   input wire logic in_mark_pos,          // Positive mark of the symbol.
   input wire logic in_mark_neg,          // Negative mark of the symbol.
   input wire logic in_data_bit,          // Binary data bit.
   input wire logic in_frame_first,       // First bit of a frame.
   output logic tx_mode_active,           // Some output form is driven.
   output logic tx_underrun,              // No symbol at a bit start.
   output logic tx_line_out_a,            // Analog line 1 drive level.
   output logic tx_line_out_a_oe,         // Analog line 1 driven.
   output logic tx_line_out_b,            // Analog line 2 drive level.
   output logic tx_line_out_b_oe,         // Analog line 2 driven.
   output logic tx_pulse_positive,        // Dual-rail positive pulse.
   output logic tx_pulse_positive_oe,     // Positive pulse driven.
   output logic tx_pulse_negative,        // Dual-rail negative pulse.
   output logic tx_pulse_negative_oe,     // Negative pulse driven.
   output logic tx_frame_marker,          // Frame start marker.
   output logic tx_frame_marker_oe,       // Frame marker driven.
   output logic tx_optical_data,          // Optical unipolar data.
   output logic tx_optical_data_oe        // Optical data driven.
);

   // ==========================================================
   // Declarations.
   tlos_pkg::tlos_mode_t mode_reg;
   tlos_pkg::tlos_mode_t mode_next;
   logic coding_seen_reg;
   logic tck_level;
   logic tck_rise;
   logic tck_fall;
   logic [tlos_pkg::TLOS_ENT_W-1:0] buf_in;
   logic [tlos_pkg::TLOS_ENT_W-1:0] buf_out;
   logic buf_valid;
   logic buf_take;
   logic [tlos_pkg::TLOS_ENT_W-1:0] cur_reg;
   logic first_half_reg;
   logic cmi_level_reg;
   logic pulse_pos;
   logic pulse_neg;
   logic opt_level;
   logic drive_digital;

   // ==========================================================
   // Helpers.
   function automatic logic ent_field(
      input logic [tlos_pkg::TLOS_ENT_W-1:0] ent,
      input int pos
   );
      ent_field = ent[pos];
   endfunction

   function automatic logic mode_is(
      input tlos_pkg::tlos_mode_t m,
      input tlos_pkg::tlos_mode_t want
   );
      mode_is = (m == want);
   endfunction

   // ==========================================================
   // Transmit clock synchroniser.
   tlos_edge_sync u_tck_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .async_in(transmit_clock),
      .level_out(tck_level),
      .rise_pulse(tck_rise),
      .fall_pulse(tck_fall)
   );

   // ==========================================================
   // Symbol buffer between the framer and the line stage.
   assign buf_in[tlos_pkg::TLOS_ENT_POS] = in_mark_pos;
   assign buf_in[tlos_pkg::TLOS_ENT_NEG] = in_mark_neg;
   assign buf_in[tlos_pkg::TLOS_ENT_BIT] = in_data_bit;
   assign buf_in[tlos_pkg::TLOS_ENT_FRM] = in_frame_first;

   // The line stage drains one symbol per transmit clock rise while a
   // form is active, so the framer stalls when no output is enabled.
   assign buf_take = tck_rise & ~mode_is(mode_reg, tlos_pkg::TLOS_MODE_OFF);

   tlos_skid_buf #(
      .WIDTH(tlos_pkg::TLOS_ENT_W),
      .DEPTH(tlos_pkg::TLOS_BUF_DEPTH)
   ) u_buf (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .wr_valid(in_valid),
      .wr_ready(in_ready),
      .wr_data(buf_in),
      .rd_valid(buf_valid),
      .rd_ready(buf_take),
      .rd_data(buf_out)
   );

   // ==========================================================
   // Coding bit history: analog lines stay off until it was one.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         coding_seen_reg <= 1'b0;
      end else if (transmit_coding_ctrl) begin
         coding_seen_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Output form selection.
   always_comb begin
      if (digital_rail_select && transmit_coding_ctrl) begin
         mode_next = tlos_pkg::TLOS_MODE_DUAL;
      end else if (digital_rail_select) begin
         mode_next = tlos_pkg::TLOS_MODE_OPTICAL;
      end else if (coding_seen_reg || transmit_coding_ctrl) begin
         mode_next = tlos_pkg::TLOS_MODE_ANALOG;
      end else begin
         mode_next = tlos_pkg::TLOS_MODE_OFF;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mode_reg <= tlos_pkg::TLOS_MODE_OFF;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // ==========================================================
   // Current bit and its half.
   // A missing symbol at a bit start sends an all-zero symbol.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cur_reg <= '0;
         first_half_reg <= 1'b0;
      end else if (buf_take) begin
         cur_reg <= buf_valid ? buf_out : '0;
         first_half_reg <= 1'b1;
      end else if (tck_fall) begin
         first_half_reg <= 1'b0;
      end
   end

   // CMI ones alternate between full-bit high and full-bit low.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cmi_level_reg <= 1'b0;
      end else if (buf_take && buf_valid &&
                   ent_field(buf_out, tlos_pkg::TLOS_ENT_BIT)) begin
         cmi_level_reg <= ~cmi_level_reg;
      end
   end

   // ==========================================================
   // Pulse shaping.
   always_comb begin
      pulse_pos = ent_field(cur_reg, tlos_pkg::TLOS_ENT_POS);
      pulse_neg = ent_field(cur_reg, tlos_pkg::TLOS_ENT_NEG);
      if (tx_baud_width_sel == tlos_pkg::TLOS_BAUD_HALF) begin
         pulse_pos = pulse_pos & first_half_reg;
         pulse_neg = pulse_neg & first_half_reg;
      end
   end

   always_comb begin
      if (tx_optical_code_sel == tlos_pkg::TLOS_CODE_NRZ) begin
         opt_level = ent_field(cur_reg, tlos_pkg::TLOS_ENT_BIT);
      end else if (ent_field(cur_reg, tlos_pkg::TLOS_ENT_BIT)) begin
         opt_level = cmi_level_reg;
      end else begin
         opt_level = ~first_half_reg;
      end
   end

   assign drive_digital = digital_rail_select;

   // ==========================================================
   // Analog line drive.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tx_line_out_a <= 1'b0;
         tx_line_out_b <= 1'b0;
         tx_line_out_a_oe <= 1'b0;
         tx_line_out_b_oe <= 1'b0;
      end else begin
         tx_line_out_a_oe <= mode_is(mode_reg,
                                     tlos_pkg::TLOS_MODE_ANALOG);
         tx_line_out_b_oe <= mode_is(mode_reg,
                                     tlos_pkg::TLOS_MODE_ANALOG);
         tx_line_out_a <= mode_is(mode_reg, tlos_pkg::TLOS_MODE_ANALOG) &
                          pulse_pos;
         tx_line_out_b <= mode_is(mode_reg, tlos_pkg::TLOS_MODE_ANALOG) &
                          pulse_neg;
      end
   end

   // ==========================================================
   // Dual-rail pulse outputs.
   // Polarity 0 gives active-low pulses, so the idle level is high.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tx_pulse_positive <= 1'b0;
         tx_pulse_negative <= 1'b0;
         tx_pulse_positive_oe <= 1'b0;
         tx_pulse_negative_oe <= 1'b0;
      end else begin
         tx_pulse_positive_oe <= drive_digital &
            mode_is(mode_reg, tlos_pkg::TLOS_MODE_DUAL);
         tx_pulse_negative_oe <= drive_digital &
            mode_is(mode_reg, tlos_pkg::TLOS_MODE_DUAL);
         tx_pulse_positive <= pulse_pos ~^ tx_output_polarity;
         tx_pulse_negative <= pulse_neg ~^ tx_output_polarity;
      end
   end

   // ==========================================================
   // Optical data and frame marker.
   // Polarity 0 gives active-high optical data.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tx_optical_data <= 1'b0;
         tx_optical_data_oe <= 1'b0;
      end else begin
         tx_optical_data_oe <= drive_digital &
            mode_is(mode_reg, tlos_pkg::TLOS_MODE_OPTICAL);
         tx_optical_data <= opt_level ^ tx_output_polarity;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tx_frame_marker <= 1'b0;
         tx_frame_marker_oe <= 1'b0;
      end else begin
         tx_frame_marker_oe <= drive_digital &
            mode_is(mode_reg, tlos_pkg::TLOS_MODE_OPTICAL);
         tx_frame_marker <= mode_is(mode_reg, tlos_pkg::TLOS_MODE_OPTICAL) &
            ent_field(cur_reg, tlos_pkg::TLOS_ENT_FRM);
      end
   end

   // ==========================================================
   // Status.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tx_mode_active <= 1'b0;
         tx_underrun <= 1'b0;
      end else begin
         tx_mode_active <= ~mode_is(mode_reg, tlos_pkg::TLOS_MODE_OFF);
         tx_underrun <= buf_take & ~buf_valid;
      end
   end

endmodule
`default_nettype wire

/* dv/tlos_line_out_props.sv */
// Concurrent checks on the transmit line output stage ports.
`timescale 1ns/10ps
`default_nettype none
module tlos_line_out_props (
   input wire logic ref_clk,              // System clock.
   input wire logic resetn,               // Reset, active low.
   input wire logic transmit_clock,       // Bit clock.
   input wire logic digital_rail_select,  // Digital form select.
   input wire logic transmit_coding_ctrl, // Coding bit.
   input wire logic tx_baud_width_sel,    // Baud width.
   input wire logic tx_output_polarity,   // Output sense.
   input wire logic tx_line_out_a_oe,     // Analog 1 driven.
   input wire logic tx_line_out_b_oe,     // Analog 2 driven.
   input wire logic tx_pulse_positive,    // Positive pulse.
   input wire logic tx_pulse_positive_oe, // Positive driven.
   input wire logic tx_pulse_negative_oe, // Negative driven.
   input wire logic tx_frame_marker,      // Frame marker.
   input wire logic tx_frame_marker_oe,   // Marker driven.
   input wire logic tx_optical_data_oe    // Optical driven.
);
   // =====
   // Helper state.
   logic coding_seen_reg;
   logic [7:0] since_rise_reg;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) coding_seen_reg <= 1'b0;
      else if (transmit_coding_ctrl) coding_seen_reg <= 1'b1;
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) since_rise_reg <= 8'hff;
      else if ($rose(transmit_clock)) since_rise_reg <= 8'h00;
      else if (since_rise_reg != 8'hff) since_rise_reg <= since_rise_reg + 8'h01;
   end
   // =====
   // Assertions.
   analog_arm_a: assert property (
      tx_line_out_a_oe || tx_line_out_b_oe |-> coding_seen_reg)
      else $error("analog line driven before coding bit");
   analog_sel_a: assert property (
      (!digital_rail_select && coding_seen_reg) [*3] |->
      tx_line_out_a_oe && tx_line_out_b_oe && !tx_pulse_positive_oe)
      else $error("analog form not selected");
   dual_sel_a: assert property (
      (digital_rail_select && transmit_coding_ctrl) [*3] |->
      tx_pulse_positive_oe && tx_pulse_negative_oe &&
      !tx_optical_data_oe && !tx_frame_marker_oe && !tx_line_out_a_oe)
      else $error("dual-rail form not selected");
   optical_sel_a: assert property (
      (digital_rail_select && !transmit_coding_ctrl) [*3] |->
      tx_optical_data_oe && tx_frame_marker_oe && !tx_pulse_negative_oe)
      else $error("optical form not selected");
   digital_float_a: assert property (
      (!digital_rail_select) [*3] |-> !(tx_pulse_positive_oe ||
      tx_pulse_negative_oe || tx_frame_marker_oe || tx_optical_data_oe))
      else $error("digital pin driven with rail select low");
   half_baud_a: assert property (
      tx_pulse_positive_oe && !tx_baud_width_sel && $fell(transmit_clock)
      |-> ##[1:8] tx_pulse_positive == !tx_output_polarity)
      else $error("half baud pulse did not end");
   full_baud_a: assert property (
      tx_pulse_positive_oe && tx_baud_width_sel && $fell(transmit_clock)
      |=> $stable(tx_pulse_positive) [*8])
      else $error("full baud pulse changed mid bit");
   launch_rise_a: assert property (
      tx_frame_marker_oe && $past(tx_frame_marker_oe) &&
      $changed(tx_frame_marker) |-> since_rise_reg inside {[2:4]})
      else $error("marker changed away from a clock rise");
endmodule
bind tlos_line_out tlos_line_out_props props_u (.ref_clk(ref_clk),
   .resetn(resetn), .transmit_clock(transmit_clock),
   .digital_rail_select(digital_rail_select),
   .transmit_coding_ctrl(transmit_coding_ctrl),
   .tx_baud_width_sel(tx_baud_width_sel),
   .tx_output_polarity(tx_output_polarity),
   .tx_line_out_a_oe(tx_line_out_a_oe), .tx_line_out_b_oe(tx_line_out_b_oe),
   .tx_pulse_positive(tx_pulse_positive),
   .tx_pulse_positive_oe(tx_pulse_positive_oe),
   .tx_pulse_negative_oe(tx_pulse_negative_oe),
   .tx_frame_marker(tx_frame_marker), .tx_frame_marker_oe(tx_frame_marker_oe),
   .tx_optical_data_oe(tx_optical_data_oe));
`default_nettype wire

/* dv/tlos_line_rx.sv */
// Far-side line receiver model that samples each bit at mid-bit.
`timescale 1ns/10ps
`default_nettype none
module tlos_line_rx (
   input wire logic ref_clk,       // System clock.
   input wire logic bit_clk,       // Transmit bit clock.
   input wire logic [5:0] pin_val, // Levels {opt, frm, neg, pos, b, a}.
   input wire logic [5:0] pin_oe,  // Enables in the same order.
   output logic s_valid,           // One cycle per sampled bit.
   output logic [5:0] s_lvl,       // Resolved levels at mid-bit.
   output logic [5:0] s_oe         // Enables at mid-bit.
);
   logic [5:0] last_reg = 6'h00;
   logic [5:0] wire_lvl;
   logic clk_q = 1'b0;
   logic armed = 1'b0;
   // A released pin shows the inverse of its last level, never a hold.
   assign wire_lvl = (pin_val & pin_oe) | (~last_reg & ~pin_oe);
   always @(posedge ref_clk) begin
      last_reg <= wire_lvl;
      clk_q <= bit_clk;
      s_valid <= 1'b0;
      if (bit_clk && !clk_q)
         armed <= |pin_oe;
      if (!bit_clk && clk_q && armed) begin
         s_valid <= 1'b1;
         s_lvl <= wire_lvl; // Marker passed on raw, never used to align.
         s_oe <= pin_oe;
      end
   end
endmodule
`default_nettype wire

/* dv/transmit_line_output_select_tb.sv */
// Self-checking bench for the transmit line output select block.
`timescale 1ns/10ps
`default_nettype none
`define TLOS_CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("Error at %0t: got %b expected %b", $time, g, e); end end
module transmit_line_output_select_tb;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic tclk = 1'b0;
   logic [5:0] tcnt = 6'h00;
   logic rail = 1'b0, coding = 1'b0, baud = 1'b0, osel = 1'b0;
   logic pol = tlos_pkg::TLOS_POL_RESET;
   logic in_valid = 1'b0;
   logic [3:0] sym = 4'h0; // Fields {frm, bit, neg, pos}.
   logic [3:0] r, sym_x;
   logic in_ready, mode_act, s_valid, urun;
   wire logic [5:0] pv, po;
   logic [5:0] s_lvl, s_oe;
   logic alt = 1'b1;
   logic [3:0] q[$];
   int fails = 0;
   int n_checks = 0;
   logic [4:0] cfg[8] = '{5'h08, 5'h0c, 5'h18, 5'h1e, 5'h10, 5'h11, 5'h12,
      5'h00};
   // =====
   // Clocks, design and far side.
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      tcnt <= (tcnt == 6'h2f) ? 6'h00 : tcnt + 6'h01;
      tclk <= (tcnt < 6'h18);
   end
   tlos_line_out dut_u (.ref_clk(ref_clk), .resetn(resetn),
      .transmit_clock(tclk), .digital_rail_select(rail),
      .transmit_coding_ctrl(coding), .tx_baud_width_sel(baud),
      .tx_output_polarity(pol), .tx_optical_code_sel(osel),
      .in_valid(in_valid), .in_ready(in_ready), .in_mark_pos(sym[0]),
      .in_mark_neg(sym[1]), .in_data_bit(sym[2]), .in_frame_first(sym[3]),
      .tx_mode_active(mode_act), .tx_underrun(urun),
      .tx_line_out_a(pv[0]), .tx_line_out_a_oe(po[0]),
      .tx_line_out_b(pv[1]), .tx_line_out_b_oe(po[1]),
      .tx_pulse_positive(pv[2]), .tx_pulse_positive_oe(po[2]),
      .tx_pulse_negative(pv[3]), .tx_pulse_negative_oe(po[3]),
      .tx_frame_marker(pv[4]), .tx_frame_marker_oe(po[4]),
      .tx_optical_data(pv[5]), .tx_optical_data_oe(po[5]));
   tlos_line_rx rx_u (.ref_clk(ref_clk), .bit_clk(tclk), .pin_val(pv),
      .pin_oe(po), .s_valid(s_valid), .s_lvl(s_lvl), .s_oe(s_oe));
   // =====
   // Feeder notes each symbol taken; watcher compares each sampled bit.
   always @(posedge ref_clk) if (resetn) begin
      if (in_valid && in_ready) q.push_back(sym);
      if (!in_valid || in_ready) begin
         r = 4'($urandom);
         in_valid <= 1'b1;
         sym <= {r[3:2], r[1] & ~r[0], r[0]};
      end
   end
   // The feeder never starves the buffer, so no bit may start empty.
   always @(posedge ref_clk) if (resetn) begin
      `TLOS_CHK(urun, 1'b0)
   end
   always @(posedge ref_clk) if (s_valid) begin
      if (q.size() == 0) begin
         fails++;
         $display("Error at %0t: bit sent without a symbol", $time);
      end else begin
         sym_x = q.pop_front();
         `TLOS_CHK(mode_act, 1'b1)
         if (!rail) begin
            `TLOS_CHK(s_oe, 6'h03)
            `TLOS_CHK(s_lvl[1:0], sym_x[1:0])
         end else if (coding) begin
            `TLOS_CHK(s_oe, 6'h0c)
            `TLOS_CHK(s_lvl[3:2], sym_x[1:0] ^ {2{~pol}})
         end else begin
            `TLOS_CHK(s_oe, 6'h30)
            `TLOS_CHK(s_lvl[4], sym_x[3])
            `TLOS_CHK(s_lvl[5], (osel ? sym_x[2] & alt : sym_x[2]) ^ pol)
         end
         // CMI ones alternate over every sent one, whatever the form.
         if (sym_x[2]) alt = ~alt;
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wait_fall();
      int i;
      i = 0;
      do begin
         @(negedge ref_clk);
         i++;
      end while (tcnt != 6'h19 && i < 60);
      if (i >= 60) begin
         fails++;
         $display("Error at %0t: bit clock stalled", $time);
         tally_and_finish();
      end
   endtask
   // =====
   // Main sequence: idle after reset, then every output form in turn.
   initial begin
      void'($urandom(61));
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) wait_fall();
      `TLOS_CHK(in_ready, 1'b0)
      `TLOS_CHK(po, 6'h00)
      `TLOS_CHK(mode_act, 1'b0)
      foreach (cfg[k]) begin
         wait_fall();
         repeat (12) @(posedge ref_clk);
         {rail, coding, baud, pol, osel} <= cfg[k];
         repeat (5) wait_fall();
      end
      repeat (4) @(posedge ref_clk);
      tally_and_finish();
   end
endmodule
`default_nettype wire
